// ==== src/dtw_pkg.sv ====
// shared constants of the dual timer and watchdog block
package dtw_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_CTRL = 6'h00;
    localparam logic [5:0] IDX_WDEN = 6'h02;
    localparam logic [5:0] IDX_STAT = 6'h03;
    localparam logic [5:0] IDX_T0CMP = 6'h04;
    localparam logic [5:0] IDX_T1CMP = 6'h08;
    localparam logic [5:0] IDX_WDT1 = 6'h0D;
    localparam logic [5:0] IDX_T0CNT = 6'h10;
    localparam logic [5:0] IDX_T1CNT = 6'h14;
    localparam logic [5:0] IDX_SRC = 6'h18;

    // timer_mode_enable_ctrl fields
    localparam int T0_EN_BIT = 0;
    localparam int T0_MODE_LSB = 1;
    localparam int T1_EN_BIT = 3;
    localparam int T1_MODE_LSB = 4;

    // watchdog_enable_ctrl and timer_watchdog_status fields
    localparam int WD_EN_BIT = 7;
    localparam int ST_T0_BIT = 0;
    localparam int ST_T1_BIT = 1;
    localparam int ST_WD_BIT = 2;
    localparam int ST_WDCLR_BIT = 3;
    localparam int ST_SW_BIT = 7;

    // gpio_source_select fields
    localparam int SRC_W = 3;
    localparam int T0_SRC_LSB = 0;
    localparam int T0_POL_BIT = 3;
    localparam int T1_SRC_LSB = 4;
    localparam int T1_POL_BIT = 7;

    // timer mode codes
    typedef logic [1:0] dtw_mode_t;
    localparam dtw_mode_t MODE_SYSCLK = 2'h0;
    localparam dtw_mode_t MODE_GPIO_EDGE = 2'h1;
    localparam dtw_mode_t MODE_PULSE = 2'h2;
    localparam dtw_mode_t MODE_TICK = 2'h3;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h00000000;
    localparam logic [23:0] RST_WDT = 24'h000000;

endpackage : dtw_pkg

// ==== src/dtw_chan.sv ====
// one 32-bit timer channel with its four counting modes
`timescale 1ns/10ps
module dtw_chan (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // configuration
    input wire logic en,
    input wire dtw_pkg::dtw_mode_t mode,
    input wire logic pol,
    input wire logic [31:0] cmp,
    // count byte writes
    input wire logic [3:0] cnt_we,
    input wire logic [7:0] wbyte,
    // filtered gpio level
    input wire logic gpio_lvl,
    // state
    output logic [31:0] cnt,
    output logic hit
);
    typedef enum logic [1:0] {ST_WAIT, ST_COUNT, ST_HALT} dtw_st_e;

    dtw_st_e st_q, st_d;
    logic [31:0] cnt_q, cnt_d;
    logic prev_q;
    logic hit_d;

    wire rise = gpio_lvl & ~prev_q;
    wire fall = ~gpio_lvl & prev_q;
    wire start_edge = pol ? fall : rise;
    wire stop_edge = pol ? rise : fall;
    wire at_cmp = (cnt_q == cmp);
    wire [31:0] cnt_inc = cnt_q + 32'h00000001;
    wire live = en & ((st_q == ST_COUNT) | ((st_q == ST_WAIT) & (mode != dtw_pkg::MODE_PULSE)));

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        hit_d = 1'b0;
        if (!en) begin
            st_d = ST_WAIT;
        end else if (live) begin
            st_d = ST_COUNT;
            unique case (mode)
                dtw_pkg::MODE_SYSCLK: begin
                    if (at_cmp) begin
                        hit_d = 1'b1;
                        st_d = ST_HALT;
                    end else begin
                        cnt_d = cnt_inc;
                    end
                end
                dtw_pkg::MODE_GPIO_EDGE: begin
                    if (at_cmp) begin
                        hit_d = 1'b1;
                        st_d = ST_HALT;
                    end else if (start_edge) begin
                        cnt_d = cnt_inc;
                    end
                end
                dtw_pkg::MODE_PULSE: begin
                    if (stop_edge) begin
                        hit_d = 1'b1;
                        st_d = ST_HALT;
                    end else begin
                        cnt_d = cnt_inc;
                    end
                end
                dtw_pkg::MODE_TICK: begin
                    cnt_d = cnt_inc;
                end
            endcase
        end else if (st_q == ST_WAIT && start_edge) begin
            st_d = ST_COUNT;
        end
        // software byte loads win over counting and re-arm a halted timer
        for (int b = 0; b < 4; b++) begin
            if (cnt_we[b]) begin
                cnt_d[8*b +: 8] = wbyte;
                if (st_d == ST_HALT) begin
                    st_d = ST_WAIT;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= ST_WAIT;
            cnt_q <= dtw_pkg::RST_WORD;
            prev_q <= 1'b0;
            hit <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            prev_q <= gpio_lvl;
            hit <= hit_d;
        end
    end

    assign cnt = cnt_q;

endmodule : dtw_chan

// ==== src/dtw_top.sv ====
// dual timer with watchdog behind an ahb-lite register slave
// Function
// - sysclk mode counts one per clock
// - compare match: flag, halt, status update
// - timer0 enable bit0, mode bits 2:1
// - timer1 enable bit3, mode bits 5:4
// - edge mode counts selected gpio edge
// - per-timer gpio source select
// - edge mode stops at compare match
// - pulse mode counts clocks after start edge
// - opposite edge flags and freezes count
// - tick mode wraps, never flags
// - running count readable while counting
// - 24-bit watchdog target from three bytes
// - watchdog runs once enable bit7 set
// - status bit3 write clears watchdog counter
// - target hit resets chip, sets bit2
// - compare 32 bits in four bytes
`timescale 1ns/10ps
module dtw_top #(
    parameter int GPIO_N = 8,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // gpio sources
    input wire logic [GPIO_N-1:0] gpio_in,
    // events
    output logic tmr0_irq,
    output logic tmr1_irq,
    output logic soft_irq,
    output logic chip_reset
);
    // bus state
    logic wr_pend_q;
    logic [5:0] wr_idx_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;

    // registers
    logic [7:0] ctrl_q;
    logic wden_q;
    logic t0_flag_q, t1_flag_q, wd_flag_q, sw_q;
    logic [31:0] cmp0_q, cmp1_q;
    logic [23:0] wdt_q;
    logic [7:0] src_q;
    logic [31:0] wd_cnt_q;
    logic chip_reset_q;

    // gpio synchronisers and filtered levels
    logic [GPIO_N-1:0] sync1_q, sync2_q, sync3_q, lvl_q;

    // channel outputs
    logic [31:0] cnt0, cnt1;
    logic hit0, hit1;

    // address phase decode
    wire acc = hsel & hready & htrans[1];
    wire [5:0] idx_a = haddr[ADDR_W-1:2];
    wire [1:0] bsel = idx_a[1:0];

    // data phase write decode
    wire [7:0] wb = hwdata[7:0];
    wire we_ctrl = wr_pend_q & (wr_idx_q == dtw_pkg::IDX_CTRL);
    wire we_wden = wr_pend_q & (wr_idx_q == dtw_pkg::IDX_WDEN);
    wire we_stat = wr_pend_q & (wr_idx_q == dtw_pkg::IDX_STAT);
    wire we_src = wr_pend_q & (wr_idx_q == dtw_pkg::IDX_SRC);
    wire [5:0] wgrp = {wr_idx_q[5:2], 2'b00};
    wire [1:0] wb_sel = wr_idx_q[1:0];
    wire we_cmp0 = wr_pend_q & (wgrp == dtw_pkg::IDX_T0CMP);
    wire we_cmp1 = wr_pend_q & (wgrp == dtw_pkg::IDX_T1CMP);
    wire we_cnt0 = wr_pend_q & (wgrp == dtw_pkg::IDX_T0CNT);
    wire we_cnt1 = wr_pend_q & (wgrp == dtw_pkg::IDX_T1CNT);
    wire we_wdt = wr_pend_q & (wgrp == {dtw_pkg::IDX_WDT1[5:2], 2'b00}) & (wb_sel != 2'b00);

    // field views
    // timer0 and timer1 enable, mode, gpio source and polarity
    wire t0_en = ctrl_q[dtw_pkg::T0_EN_BIT];
    wire [1:0] t0_mode = ctrl_q[dtw_pkg::T0_MODE_LSB +: 2];
    wire t1_en = ctrl_q[dtw_pkg::T1_EN_BIT];
    wire [1:0] t1_mode = ctrl_q[dtw_pkg::T1_MODE_LSB +: 2];
    wire [dtw_pkg::SRC_W-1:0] t0_src = src_q[dtw_pkg::T0_SRC_LSB +: dtw_pkg::SRC_W];
    wire [dtw_pkg::SRC_W-1:0] t1_src = src_q[dtw_pkg::T1_SRC_LSB +: dtw_pkg::SRC_W];
    wire t0_pol = src_q[dtw_pkg::T0_POL_BIT];
    wire t1_pol = src_q[dtw_pkg::T1_POL_BIT];

    wire t0_lvl = (32'(t0_src) < GPIO_N) ? lvl_q[t0_src] : 1'b0;
    wire t1_lvl = (32'(t1_src) < GPIO_N) ? lvl_q[t1_src] : 1'b0;

    // per-byte count write strobes
    wire [3:0] cnt0_we = we_cnt0 ? (4'h1 << wb_sel) : 4'h0;
    wire [3:0] cnt1_we = we_cnt1 ? (4'h1 << wb_sel) : 4'h0;

    // gpio sync: a change counts once second and third stage agree
    genvar g;
    generate
        for (g = 0; g < GPIO_N; g++) begin : g_sync
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sync1_q[g] <= 1'b0;
                    sync2_q[g] <= 1'b0;
                    sync3_q[g] <= 1'b0;
                    lvl_q[g] <= 1'b0;
                end else begin
                    sync1_q[g] <= gpio_in[g];
                    sync2_q[g] <= sync1_q[g];
                    sync3_q[g] <= sync2_q[g];
                    if (sync2_q[g] == sync3_q[g]) begin
                        lvl_q[g] <= sync3_q[g];
                    end
                end
            end
        end
    endgenerate

    // timer channels
    dtw_chan u_t0 (
        .hclk(hclk),
        .hresetn(hresetn),
        .en(t0_en),
        .mode(t0_mode),
        .pol(t0_pol),
        .cmp(cmp0_q),
        .cnt_we(cnt0_we),
        .wbyte(wb),
        .gpio_lvl(t0_lvl),
        .cnt(cnt0),
        .hit(hit0)
    );

    dtw_chan u_t1 (
        .hclk(hclk),
        .hresetn(hresetn),
        .en(t1_en),
        .mode(t1_mode),
        .pol(t1_pol),
        .cmp(cmp1_q),
        .cnt_we(cnt1_we),
        .wbyte(wb),
        .gpio_lvl(t1_lvl),
        .cnt(cnt1),
        .hit(hit1)
    );

    // read selection
    wire [5:0] rgrp = {idx_a[5:2], 2'b00};
    wire [31:0] wdt_word = {wdt_q, 8'h00};
    wire [7:0] stat_rd = {sw_q, 4'h0, wd_flag_q, t1_flag_q, t0_flag_q};
    wire [7:0] cmp0_b = cmp0_q[8*bsel +: 8];
    wire [7:0] cmp1_b = cmp1_q[8*bsel +: 8];
    wire [7:0] cnt0_b = cnt0[8*bsel +: 8];
    wire [7:0] cnt1_b = cnt1[8*bsel +: 8];
    wire [7:0] wdt_b = wdt_word[8*bsel +: 8];
    wire [7:0] rd_byte =
        (idx_a == dtw_pkg::IDX_CTRL) ? ctrl_q :
        (idx_a == dtw_pkg::IDX_WDEN) ? {wden_q, 7'h00} :
        (idx_a == dtw_pkg::IDX_STAT) ? stat_rd :
        (rgrp == dtw_pkg::IDX_T0CMP) ? cmp0_b :
        (rgrp == dtw_pkg::IDX_T1CMP) ? cmp1_b :
        (rgrp == {dtw_pkg::IDX_WDT1[5:2], 2'b00}) ? wdt_b :
        (rgrp == dtw_pkg::IDX_T0CNT) ? cnt0_b :
        (rgrp == dtw_pkg::IDX_T1CNT) ? cnt1_b :
        (idx_a == dtw_pkg::IDX_SRC) ? src_q : 8'h00;

    // bus phases: zero wait states, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 6'h00;
            hrdata_q <= dtw_pkg::RST_WORD;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            if (hready) begin
                wr_pend_q <= acc & hwrite;
                wr_idx_q <= idx_a;
            end
            if (acc & ~hwrite) begin
                hrdata_q <= {24'h000000, rd_byte};
            end
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    // control, source and enable registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= dtw_pkg::RST_BYTE;
            wden_q <= 1'b0;
            src_q <= dtw_pkg::RST_BYTE;
            sw_q <= 1'b0;
        end else begin
            if (we_ctrl) begin
                ctrl_q <= wb;
            end
            if (we_wden) begin
                wden_q <= wb[dtw_pkg::WD_EN_BIT];
            end
            if (we_src) begin
                src_q <= wb;
            end
            if (we_stat) begin
                sw_q <= wb[dtw_pkg::ST_SW_BIT];
            end
        end
    end

    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_cmp
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cmp0_q[8*b +: 8] <= dtw_pkg::RST_BYTE;
                    cmp1_q[8*b +: 8] <= dtw_pkg::RST_BYTE;
                end else begin
                    if (we_cmp0 && wb_sel == 2'(b)) begin
                        cmp0_q[8*b +: 8] <= wb;
                    end
                    if (we_cmp1 && wb_sel == 2'(b)) begin
                        cmp1_q[8*b +: 8] <= wb;
                    end
                end
            end
        end
        for (b = 1; b < 4; b++) begin : g_wdt
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    wdt_q[8*(b-1) +: 8] <= dtw_pkg::RST_BYTE;
                end else if (we_wdt && wb_sel == 2'(b)) begin
                    wdt_q[8*(b-1) +: 8] <= wb;
                end
            end
        end
    endgenerate

    // status flags: hardware set wins over write-one clear
    wire clr_t0 = we_stat & wb[dtw_pkg::ST_T0_BIT];
    wire clr_t1 = we_stat & wb[dtw_pkg::ST_T1_BIT];
    wire clr_wd = we_stat & wb[dtw_pkg::ST_WD_BIT];
    wire wd_clr = we_stat & wb[dtw_pkg::ST_WDCLR_BIT];
    wire wd_hit = wden_q & ~wd_clr & (wd_cnt_q[31:8] == wdt_q);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            t0_flag_q <= 1'b0;
            t1_flag_q <= 1'b0;
            wd_flag_q <= 1'b0;
        end else begin
            t0_flag_q <= hit0 | (t0_flag_q & ~clr_t0);
            t1_flag_q <= hit1 | (t1_flag_q & ~clr_t1);
            wd_flag_q <= wd_hit | (wd_flag_q & ~clr_wd);
        end
    end

    // watchdog counter on the system clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wd_cnt_q <= dtw_pkg::RST_WORD;
            chip_reset_q <= 1'b0;
        end else begin
            chip_reset_q <= wd_hit;
            if (!wden_q || wd_clr || wd_hit) begin
                wd_cnt_q <= dtw_pkg::RST_WORD;
            end else begin
                wd_cnt_q <= wd_cnt_q + 32'h00000001;
            end
        end
    end

    // outputs
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign hrdata = hrdata_q;
    assign tmr0_irq = t0_flag_q;
    assign tmr1_irq = t1_flag_q;
    assign soft_irq = sw_q;
    assign chip_reset = chip_reset_q;

endmodule : dtw_top

// ==== testbench/dtw_properties.sv ====
// port assertions for the dual timer and watchdog top
`timescale 1ns/10ps
module dtw_properties #(
    parameter int GPIO_N = 8,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // pins and events
    input wire logic [GPIO_N-1:0] gpio_in,
    input wire logic tmr0_irq,
    input wire logic tmr1_irq,
    input wire logic soft_irq,
    input wire logic chip_reset
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic wr_q;
    logic rdc_q;
    logic wd_en_q;
    logic [5:0] a_q;
    logic [7:0] ctrl_q;
    logic [7:0] exp_q;
    logic [9:0] wd_cyc_q;
    wire take = hsel && hready && htrans[1];
    wire stw = wr_q && a_q == dtw_pkg::IDX_STAT;
    wire [9:0] wd_cyc_d = (!wd_en_q || chip_reset || (stw && hwdata[3])) ? 10'h000 : wd_cyc_q + 10'h001;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rdc_q <= 1'b0;
            wd_en_q <= 1'b0;
            a_q <= 6'h00;
            ctrl_q <= 8'h00;
            exp_q <= 8'h00;
            wd_cyc_q <= 10'h000;
        end else begin
            wr_q <= take && hwrite;
            rdc_q <= take && !hwrite && haddr[7:2] == dtw_pkg::IDX_CTRL;
            a_q <= haddr[7:2];
            exp_q <= ctrl_q;
            if (wr_q && a_q == dtw_pkg::IDX_CTRL) ctrl_q <= hwdata[7:0];
            if (wr_q && a_q == dtw_pkg::IDX_WDEN) wd_en_q <= hwdata[7];
            wd_cyc_q <= wd_cyc_d;
        end
    end
    chk_zero_wait_okay: assert property (hreadyout && !hresp)
        else $error("slave stalled or answered with error");
    chk_rdata_upper_zero: assert property (hrdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    chk_ctrl_readback: assert property (rdc_q |-> hrdata[7:0] == exp_q)
        else $error("control register read differs from last write");
    chk_irq0_sticky: assert property ($fell(tmr0_irq) |-> $past(stw && hwdata[0]))
        else $error("timer0 flag dropped without clear write");
    chk_irq1_sticky: assert property ($fell(tmr1_irq) |-> $past(stw && hwdata[1]))
        else $error("timer1 flag dropped without clear write");
    chk_reset_one_cycle: assert property (chip_reset |=> !chip_reset)
        else $error("chip reset pulse longer than one cycle");
    chk_wd_needs_enable: assert property (chip_reset |-> $past(wd_en_q))
        else $error("chip reset while watchdog disabled");
    chk_wd_clear_restarts: assert property (chip_reset |-> wd_cyc_q >= 10'd128)
        else $error("chip reset too soon after clear or enable");
    cover property (chip_reset);
    cover property ($rose(tmr0_irq));
    cover property ($rose(tmr1_irq));
endmodule : dtw_properties

// ==== testbench/dtw_gpio_model.sv ====
// behavioural gpio pins that feed the timer sources
`timescale 1ns/10ps
module dtw_gpio_model (
    // clock
    input wire logic hclk,
    // pins
    output logic [7:0] pins
);
    initial pins = 8'h00;
    // one edge out and one back per pulse
    task automatic pulse(input int pin, input int w);
        pins[pin] <= !pins[pin];
        repeat (w) @(posedge hclk);
        pins[pin] <= !pins[pin];
        repeat (w) @(posedge hclk);
    endtask : pulse
    task automatic set(input int pin, input logic lvl);
        pins[pin] <= lvl;
        repeat (8) @(posedge hclk);
    endtask : set
endmodule : dtw_gpio_model

// ==== testbench/tb_dual_timer_with_watchdog.sv ====
// self-checking bench for the dual timer and watchdog block
`timescale 1ns/10ps
module tb_dual_timer_with_watchdog;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    wire logic hreadyout, hresp, tmr0_irq, tmr1_irq, soft_irq, chip_reset;
    wire logic [31:0] hrdata;
    wire logic [7:0] gpio_in;
    logic rd_ph = 1'b0;
    logic [15:0] q[$];
    logic [5:0] regs[9] = '{6'h00, 6'h02, 6'h03, 6'h07, 6'h0C, 6'h0F, 6'h13, 6'h17, 6'h30};
    logic [31:0] v;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    int wdc = 0;
    int seed = 32'h5bcb;
    int n, p, c;
    always #20 hclk = ~hclk;
    dtw_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .gpio_in(gpio_in),
        .tmr0_irq(tmr0_irq), .tmr1_irq(tmr1_irq), .soft_irq(soft_irq), .chip_reset(chip_reset));
    dtw_gpio_model i_gpio (.hclk(hclk), .pins(gpio_in));
    task automatic check(input logic ok);
        checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("Error at %0t: result differs from expectation", $time);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    task automatic xfer(input logic [5:0] idx, input logic w, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {idx, 2'b00};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : xfer
    task automatic rd(input logic [5:0] idx, input logic [7:0] m, input logic [7:0] e);
        q.push_back({m, e});
        xfer(idx, 1'b0, 8'h00);
    endtask : rd
    task automatic rdv(input logic [5:0] idx, output logic [31:0] r);
        for (int i = 0; i < 4; i++) begin
            rd(idx + 6'(i), 8'h00, 8'h00);
            r[8*i+:8] = hrdata[7:0];
        end
    endtask : rdv
    task automatic wr32(input logic [5:0] idx, input logic [31:0] d);
        for (int i = 0; i < 4; i++) xfer(idx + 6'(i), 1'b1, d[8*i+:8]);
    endtask : wr32
    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (regs[i]) rd(regs[i], 8'hFF, dtw_pkg::RST_BYTE);
    endtask : do_reset
    always @(posedge hclk) begin
        logic [15:0] e;
        if (rd_ph && q.size() > 0) begin
            e = q.pop_front();
            check((hrdata[7:0] & e[15:8]) === e[7:0] && hrdata[31:8] === 24'h000000);
        end
        rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
        if (chip_reset === 1'b1) wdc++;
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            finish_test();
        end
    end
    initial begin
        do_reset();
        c = 32'h20 + ($random(seed) & 32'h1F);
        wr32(6'h10, 32'h0);
        wr32(6'h04, c);
        xfer(6'h00, 1'b1, 8'h01);
        n = 0;
        while (tmr0_irq !== 1'b1 && n < 200) begin
            @(posedge hclk);
            n++;
        end
        check(n >= c && n <= c + 3);
        rdv(6'h10, v);
        check(v === c);
        rd(6'h03, 8'h07, 8'h01);
        xfer(6'h00, 1'b1, 8'h00);
        xfer(6'h03, 1'b1, 8'h01);
        rd(6'h03, 8'h01, 8'h00);
        wr32(6'h10, 32'hFFFFFFF0);
        xfer(6'h00, 1'b1, 8'h07);
        repeat (40) @(posedge hclk);
        rd(6'h13, 8'hFF, 8'h00);
        rd(6'h00, 8'hFF, 8'h07);
        check(tmr0_irq === 1'b0);
        xfer(6'h00, 1'b1, 8'h00);
        p = $random(seed) & 7;
        c = 3 + ($random(seed) & 3);
        xfer(6'h18, 1'b1, {1'b0, p[2:0], 4'h0});
        wr32(6'h14, 32'h0);
        wr32(6'h08, c);
        xfer(6'h00, 1'b1, 8'h18);
        i_gpio.pulse((p + 1) % 8, 6);
        rd(6'h14, 8'hFF, 8'h00);
        repeat (c + 2) i_gpio.pulse(p, 6);
        rd(6'h14, 8'hFF, c[7:0]);
        check(tmr1_irq === 1'b1);
        xfer(6'h00, 1'b1, 8'h00);
        for (int pol = 0; pol < 2; pol++) begin
            p = $random(seed) & 7;
            n = 10 + ($random(seed) & 15);
            i_gpio.set(p, pol[0]);
            xfer(6'h18, 1'b1, {4'h0, pol[0], p[2:0]});
            wr32(6'h10, 32'h0);
            xfer(6'h00, 1'b1, 8'h05);
            i_gpio.pulse(p, n);
            rdv(6'h10, v);
            check(v >= n - 1 && v <= n + 1);
            check(40 * (v - 32'h0) <= 40 * (n + 1));
            check(tmr0_irq === 1'b1);
            xfer(6'h00, 1'b1, 8'h00);
            xfer(6'h03, 1'b1, 8'h01);
        end
        xfer(6'h0D, 1'b1, 8'h01);
        xfer(6'h0E, 1'b1, 8'h00);
        xfer(6'h0F, 1'b1, 8'h00);
        rd(6'h0D, 8'hFF, 8'h01);
        rd(6'h0C, 8'hFF, 8'h00);
        xfer(6'h02, 1'b1, 8'h80);
        rd(6'h02, 8'hFF, 8'h80);
        repeat (3) begin
            repeat (150) @(posedge hclk);
            xfer(6'h03, 1'b1, 8'h08);
        end
        check(wdc == 0);
        n = 0;
        while (chip_reset !== 1'b1 && n < 400) begin
            @(posedge hclk);
            n++;
        end
        check(n >= 250 && n <= 262);
        rd(6'h03, 8'h04, 8'h04);
        xfer(6'h03, 1'b1, 8'h04);
        rd(6'h03, 8'h04, 8'h00);
        xfer(6'h02, 1'b1, 8'h00);
        n = wdc;
        repeat (600) @(posedge hclk);
        check(wdc == n);
        do_reset();
        rd(6'h00, 8'hFF, 8'h00);
        finish_test();
    end
endmodule : tb_dual_timer_with_watchdog
bind dtw_top dtw_properties #(.GPIO_N(GPIO_N), .ADDR_W(ADDR_W)) i_props (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .gpio_in(gpio_in), .tmr0_irq(tmr0_irq), .tmr1_irq(tmr1_irq),
    .soft_irq(soft_irq), .chip_reset(chip_reset));
